/* File: rtl/pad_function_multiplexer.sv */
// Function
// RULE_01: Selector values 00 to 11 route alternate functions zero to three out.
// RULE_02: An input-only function sees the pad only while input buffer is on; the NMI tap reads the pad with the buffer off.
// RULE_03: Every pad input fans out to all peripherals that can use it.
// RULE_04: Multi-source peripheral inputs take the pad chosen by software.
// RULE_05: Each pad keeps its reset configuration during and after reset.
// RULE_06: A pad with the nonmaskable interrupt selected ignores its selector.
// RULE_07: After reset all pads are GPIO except the four debug-port pads.
// RULE_08: The TDO pad resets with selector two so it drives TDO.
// RULE_09: The TDO output enable resets to one and acts once selector is zero.
// RULE_10: The TDO pad comes up with medium drive.
// RULE_11: Every wakeup pad also acts as an external interrupt source.
// RULE_12: Marked wakeup inputs cannot leave standby but still wake otherwise.
// RULE_13: Boot-only functions work only while booting and not later.
// RULE_14: One configuration register per pad, indexed port*16 plus pin.
`default_nettype none
module pad_function_multiplexer
    import pad_mux_pkg::*;
(
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_arst_n,
    input  wire logic                   i_booting,
    input  wire logic                   i_standby,
    input  wire logic                   i_cfg_wr_en,
    input  wire logic [PAD_W-1:0]       i_cfg_wr_pad,
    input  wire logic [CFG_W-1:0]       i_cfg_wr_data,
    input  wire logic [PAD_W-1:0]       i_cfg_rd_pad,
    input  wire logic [SEL_INPUTS*SRC_W-1:0] i_input_pad_select_field,
    input  wire logic [PAD_W*SEL_INPUTS*SRC_OPTIONS-1:0] i_src_pad_map,
    input  wire logic [PAD_COUNT-1:0]   i_wakeup_pad_mask,
    input  wire logic [PAD_COUNT-1:0]   i_no_standby_exit_mask,
    input  wire logic [PAD_COUNT-1:0]   i_boot_func_mask,
    input  wire logic [PAD_COUNT-1:0]   i_alt0_out,
    input  wire logic [PAD_COUNT-1:0]   i_alt1_out,
    input  wire logic [PAD_COUNT-1:0]   i_alt2_out,
    input  wire logic [PAD_COUNT-1:0]   i_alt3_out,
    input  wire logic [PAD_COUNT-1:0]   i_alt0_oe,
    input  wire logic [PAD_COUNT-1:0]   i_alt1_oe,
    input  wire logic [PAD_COUNT-1:0]   i_alt2_oe,
    input  wire logic [PAD_COUNT-1:0]   i_alt3_oe,
    input  wire logic [PAD_COUNT-1:0]   i_pad_in,
    output logic [PAD_COUNT-1:0]        o_pad_out,
    output logic [PAD_COUNT-1:0]        o_pad_oe,
    output logic [PAD_COUNT-1:0]        o_pad_medium_drive,
    output logic [PAD_COUNT-1:0]        o_periph_in,
    output logic [SEL_INPUTS-1:0]       o_selected_in,
    output logic [PAD_COUNT-1:0]        o_nmi_in,
    output logic [PAD_COUNT-1:0]        o_external_irq_line,
    output logic [PAD_COUNT-1:0]        o_wakeup_in,
    output logic [PAD_COUNT-1:0]        o_standby_exit,
    output logic [CFG_W-1:0]            o_cfg_rd_data
);
    pad_cfg_if cfg_bus ();

    // The boot phase reaches the mux through the carrier.
    assign cfg_bus.booting = i_booting;

    // Configuration store, one word per pad.
    pad_cfg_store u_store (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_wr_en   (i_cfg_wr_en),
        .i_wr_pad  (i_cfg_wr_pad),
        .i_wr_data (i_cfg_wr_data),
        .cfg_bus   (cfg_bus.store)
    ); // [RULE_14]

    logic [PAD_COUNT-1:0] next_out;
    logic [PAD_COUNT-1:0] next_oe;
    logic [PAD_COUNT-1:0] next_in;
    logic [PAD_COUNT-1:0] next_wake;
    logic [PAD_COUNT-1:0] boot_locked;

    // Boot-only functions fall silent once the boot sequence is over.
    always_comb begin
        for (int p = 0; p < PAD_COUNT; p++) begin
            boot_locked[p] = i_boot_func_mask[p] && !cfg_bus.booting
                && cfg_bus.cfg[p].alt_func_select != AF_ZERO; // [RULE_13]
        end
    end

    // Output routing per pad from its selector.
    always_comb begin
        for (int p = 0; p < PAD_COUNT; p++) begin
            pad_config_t c;
            c = cfg_bus.cfg[p];
            next_in[p] = c.input_buffer_enable & i_pad_in[p]; // [RULE_02]
            if (c.nmi_select) begin
                next_out[p] = 1'b0; // [RULE_06]
                next_oe[p] = 1'b0;
            end else if (boot_locked[p]) begin
                next_out[p] = 1'b0; // [RULE_13]
                next_oe[p] = 1'b0;
            end else begin
                unique case (c.alt_func_select) // [RULE_01]
                    AF_ZERO: begin
                        next_out[p] = i_alt0_out[p];
                        // GPIO drives when its enable bit is set.
                        next_oe[p] = c.output_buffer_enable; // [RULE_09]
                    end
                    AF_ONE: begin
                        next_out[p] = i_alt1_out[p];
                        next_oe[p] = i_alt1_oe[p];
                    end
                    AF_TWO: begin
                        next_out[p] = i_alt2_out[p];
                        next_oe[p] = i_alt2_oe[p]; // [RULE_08]
                    end
                    AF_THREE: begin
                        next_out[p] = i_alt3_out[p];
                        next_oe[p] = i_alt3_oe[p];
                    end
                endcase
            end
        end
    end

    // Registered pad level, low while reset is held.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pad_out <= '0;
        end else begin
            o_pad_out <= next_out;
        end
    end

    // Registered output enable, every pad high impedance in reset.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pad_oe <= '0; // [RULE_07]
        end else begin
            o_pad_oe <= next_oe;
        end
    end

    // Drive setting that a pad comes out of reset with.
    function automatic logic reset_medium(input int p);
        pad_config_t r;
        r = reset_config(PAD_W'(p));
        return r.medium_drive;
    endfunction

    // Drive strength follows each pad's configuration, and the reset
    // setting already applies while reset is asserted.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int p = 0; p < PAD_COUNT; p++) begin
                o_pad_medium_drive[p] <= reset_medium(p); // [RULE_05]
            end
        end else begin
            for (int p = 0; p < PAD_COUNT; p++) begin
                o_pad_medium_drive[p] <=
                    cfg_bus.cfg[p].medium_drive; // [RULE_10]
            end
        end
    end

    // Pads that feed a wakeup input, seen through the input buffer.
    assign next_wake = next_in & i_wakeup_pad_mask; // [RULE_11]

    // Every consumer on o_periph_in gets the same buffered level.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_periph_in <= '0;
        end else begin
            o_periph_in <= next_in; // [RULE_03]
        end
    end

    // Nonmaskable interrupt tap, live only where it is selected.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_nmi_in <= '0;
        end else begin
            for (int p = 0; p < PAD_COUNT; p++) begin
                o_nmi_in[p] <= cfg_bus.cfg[p].nmi_select & i_pad_in[p];
            end
        end
    end

    // Wakeup pads double as external interrupt sources.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_external_irq_line <= '0;
        end else begin
            o_external_irq_line <= next_wake; // [RULE_11]
        end
    end

    // Wakeup inputs, whether or not they may end standby.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wakeup_in <= '0;
        end else begin
            o_wakeup_in <= next_wake;
        end
    end

    // Marked pads still wake, but never end standby.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_standby_exit <= '0;
        end else begin
            o_standby_exit <= next_wake & ~i_no_standby_exit_mask
                & {PAD_COUNT{i_standby}}; // [RULE_12]
        end
    end

    // Pad that option sel names for multi-source input k.
    function automatic logic [PAD_W-1:0] source_pad(
        input int               k,
        input logic [SRC_W-1:0] sel
    );
        return i_src_pad_map[(k*SRC_OPTIONS+int'(sel))*PAD_W +: PAD_W];
    endfunction

    // Software-chosen source for multi-source peripheral inputs.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_selected_in <= '0;
        end else begin
            for (int k = 0; k < SEL_INPUTS; k++) begin
                o_selected_in[k] <= next_in[source_pad(k,
                    i_input_pad_select_field[k*SRC_W +: SRC_W])]; // [RULE_04]
            end
        end
    end

    // Readback of one configuration word.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cfg_rd_data <= '0;
        end else begin
            o_cfg_rd_data <= cfg_bus.cfg[i_cfg_rd_pad];
        end
    end
endmodule
`default_nettype wire

/* File: rtl/pad_mux_pkg.sv */
`default_nettype none
package pad_mux_pkg;
    // Pad numbering: index is sixteen times the port plus the pin.
    localparam int PORT_COUNT = 8;
    localparam int PIN_COUNT = 16;
    localparam int PAD_COUNT = PORT_COUNT * PIN_COUNT;
    localparam int PAD_W = 7;
    localparam int SEL_W = 2;
    // Debug-port pads: port C pins 0 and 1, port H pins 9 and 10.
    localparam logic [PAD_W-1:0] PAD_TDI = 7'h20;
    localparam logic [PAD_W-1:0] PAD_TDO = 7'h21;
    localparam logic [PAD_W-1:0] PAD_TCK = 7'h79;
    localparam logic [PAD_W-1:0] PAD_TMS = 7'h7A;
    // Alternate-function selector codes.
    localparam logic [SEL_W-1:0] AF_ZERO = 2'h0;
    localparam logic [SEL_W-1:0] AF_ONE = 2'h1;
    localparam logic [SEL_W-1:0] AF_TWO = 2'h2;
    localparam logic [SEL_W-1:0] AF_THREE = 2'h3;
    // Configuration word layout.
    typedef struct packed {
        logic             boot_only;
        logic             nmi_select;
        logic             medium_drive;
        logic             input_buffer_enable;
        logic             output_buffer_enable;
        logic [SEL_W-1:0] alt_func_select;
    } pad_config_t;
    localparam int CFG_W = 7;
    // Reset values: plain pad, and the debug-pad variants.
    localparam pad_config_t RST_PLAIN = 7'h00;
    localparam pad_config_t RST_DBG_IN = 7'h08;
    localparam pad_config_t RST_TDO = 7'h16; // [RULE_08]
    // Peripheral inputs that can be fed from more than one pad.
    localparam int SEL_INPUTS = 4;
    localparam int SRC_W = 2;
    localparam int SRC_OPTIONS = 4;

    function automatic pad_config_t reset_config(input logic [PAD_W-1:0] idx);
        if (idx == PAD_TDO) begin
            return RST_TDO;
        end else if (idx == PAD_TDI || idx == PAD_TCK || idx == PAD_TMS) begin
            return RST_DBG_IN; // [RULE_07]
        end
        return RST_PLAIN;
    endfunction
endpackage
`default_nettype wire

/* File: rtl/pad_cfg_if.sv */
`default_nettype none
// Carries the configuration words from the store to the mux.
interface pad_cfg_if;
    import pad_mux_pkg::*;
    pad_config_t cfg [PAD_COUNT];
    logic        booting;
    modport store (output cfg, input booting);
    modport mux (input cfg, input booting);
endinterface
`default_nettype wire

/* File: rtl/pad_cfg_store.sv */
`default_nettype none
module pad_cfg_store
    import pad_mux_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_arst_n,
    input  wire logic              i_wr_en,
    input  wire logic [PAD_W-1:0]  i_wr_pad,
    input  wire logic [CFG_W-1:0]  i_wr_data,
    pad_cfg_if.store               cfg_bus
);
    // One configuration register per pad, held until software writes it.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int p = 0; p < PAD_COUNT; p++) begin
                cfg_bus.cfg[p] <= reset_config(PAD_W'(p)); // [RULE_05]
            end
        end else if (i_wr_en) begin
            // Software cannot set the boot_only bit; a write always stores zero there.
            cfg_bus.cfg[i_wr_pad] <= {1'b0, i_wr_data[CFG_W-2:0]}; // [RULE_13]
        end
    end
endmodule
`default_nettype wire

/* File: verif/pad_mux_props.sv */
`default_nettype none
// Port-level relations that the pad multiplexer must keep every cycle.
module pad_mux_props
    import pad_mux_pkg::*;
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_arst_n,
    input  wire logic                 i_standby,
    input  wire logic                 i_cfg_wr_en,
    input  wire logic [PAD_W-1:0]     i_cfg_wr_pad,
    input  wire logic [CFG_W-1:0]     i_cfg_wr_data,
    input  wire logic [PAD_W-1:0]     i_cfg_rd_pad,
    input  wire logic [PAD_COUNT-1:0] i_wakeup_pad_mask,
    input  wire logic [PAD_COUNT-1:0] i_no_standby_exit_mask,
    input  wire logic [PAD_COUNT-1:0] i_pad_in,
    input  wire logic [PAD_COUNT-1:0] o_pad_oe,
    input  wire logic [PAD_COUNT-1:0] o_periph_in,
    input  wire logic [PAD_COUNT-1:0] o_nmi_in,
    input  wire logic [PAD_COUNT-1:0] o_external_irq_line,
    input  wire logic [PAD_COUNT-1:0] o_wakeup_in,
    input  wire logic [PAD_COUNT-1:0] o_standby_exit,
    input  wire logic [CFG_W-1:0]     o_cfg_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Every check runs on the system clock and pauses in reset.
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    property p_nmi; (o_nmi_in & ~$past(i_pad_in)) == '0; endproperty
    a_nmi: assert property (p_nmi)
        else $error("nmi input high on a low pad");
    property p_fan; (o_periph_in & ~$past(i_pad_in)) == '0; endproperty
    a_fan: assert property (p_fan)
        else $error("peripheral input high on a low pad");
    property p_wake;
        (o_wakeup_in & ~$past(i_pad_in & i_wakeup_pad_mask)) == '0;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wakeup input from an unmapped or low pad");
    property p_irq; o_external_irq_line == o_wakeup_in; endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt line differs from wakeup input");
    property p_noexit;
        (o_standby_exit & $past(i_no_standby_exit_mask)) == '0;
    endproperty
    a_noexit: assert property (p_noexit)
        else $error("marked wakeup input left standby");
    property p_idle; !$past(i_standby) |-> o_standby_exit == '0; endproperty
    a_idle: assert property (p_idle)
        else $error("standby exit outside standby");
    property p_rdback;
        i_cfg_wr_en && i_cfg_wr_pad == i_cfg_rd_pad
            ##1 !i_cfg_wr_en && $stable(i_cfg_rd_pad)
            |=> o_cfg_rd_data == {1'b0, $past(i_cfg_wr_data[5:0], 2)};
    endproperty
    a_rdback: assert property (p_rdback)
        else $error("readback differs from written word");
    property p_quiet; $rose(i_arst_n) |-> o_pad_oe == '0; endproperty
    a_quiet: assert property (p_quiet)
        else $error("pad driven at reset release");
endmodule
`default_nettype wire

/* File: verif/periph_model.sv */
`default_nettype none
// Peripheral side: function k drives ones on pads whose index mod 4 is k.
module periph_model
    import pad_mux_pkg::*;
(
    output logic [PAD_COUNT-1:0] o_a0,
    output logic [PAD_COUNT-1:0] o_a1,
    output logic [PAD_COUNT-1:0] o_a2,
    output logic [PAD_COUNT-1:0] o_a3,
    output logic [PAD_COUNT-1:0] o_e0,
    output logic [PAD_COUNT-1:0] o_e1,
    output logic [PAD_COUNT-1:0] o_e2,
    output logic [PAD_COUNT-1:0] o_e3
);
    timeunit 1ns;
    timeprecision 1ps;
    // Function two never enables, so its pads show an idle driver.
    assign o_a0 = {32{4'h1}};
    assign o_a1 = {32{4'h2}};
    assign o_a2 = {32{4'h4}};
    assign o_a3 = {32{4'h8}};
    assign o_e0 = '1;
    assign o_e1 = '1;
    assign o_e2 = '0;
    assign o_e3 = '1;
endmodule
`default_nettype wire

/* File: verif/pad_function_multiplexer_bench.sv */
`default_nettype none
module pad_function_multiplexer_bench
    import pad_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 i_sys_clk, i_arst_n, i_booting, i_standby;
    logic                 i_cfg_wr_en;
    logic [PAD_W-1:0]     i_cfg_wr_pad, i_cfg_rd_pad;
    logic [CFG_W-1:0]     i_cfg_wr_data, o_cfg_rd_data;
    logic [7:0]           i_input_pad_select_field;
    logic [111:0]         i_src_pad_map;
    logic [PAD_COUNT-1:0] i_wakeup_pad_mask, i_no_standby_exit_mask;
    logic [PAD_COUNT-1:0] i_boot_func_mask, i_pad_in;
    logic [PAD_COUNT-1:0] i_alt0_out, i_alt1_out, i_alt2_out, i_alt3_out;
    logic [PAD_COUNT-1:0] i_alt0_oe, i_alt1_oe, i_alt2_oe, i_alt3_oe;
    logic [PAD_COUNT-1:0] o_pad_out, o_pad_oe, o_pad_medium_drive;
    logic [PAD_COUNT-1:0] o_periph_in, o_nmi_in, o_external_irq_line;
    logic [PAD_COUNT-1:0] o_wakeup_in, o_standby_exit;
    logic [SEL_INPUTS-1:0] o_selected_in;
    int                   mismatches, n_compared;
    periph_model partner (.o_a0(i_alt0_out), .o_a1(i_alt1_out),
        .o_a2(i_alt2_out), .o_a3(i_alt3_out), .o_e0(i_alt0_oe),
        .o_e1(i_alt1_oe), .o_e2(i_alt2_oe), .o_e3(i_alt3_oe));
    pad_function_multiplexer uut (.*);
    // Free-running system clock.
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Drops the write strobe low, then lets n edges land.
    task automatic settle(int n);
        i_cfg_wr_en = 1'b0;
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // Holds the strobe up; each back-to-back write re-assigns it high.
    task automatic wr(logic [6:0] pad, logic [6:0] data);
        i_cfg_wr_en = 1'b1;
        i_cfg_wr_pad = pad;
        i_cfg_wr_data = data;
        @(posedge i_sys_clk);
        #1;
    endtask
    task automatic rd(logic [6:0] pad, logic [6:0] exp);
        i_cfg_rd_pad = pad;
        settle(2);
        chk("cfg", {1'b0, o_cfg_rd_data}, {1'b0, exp});
    endtask
    // A hang ends the run as a failure.
    initial begin
        #100us;
        mismatches++;
        conclude();
    end
    initial begin
        {mismatches, n_compared, i_arst_n, i_booting, i_standby} = '0;
        {i_cfg_wr_en, i_cfg_wr_pad, i_cfg_wr_data, i_cfg_rd_pad} = '0;
        i_src_pad_map = {98'h0, PAD_TDI, 7'h00};
        i_input_pad_select_field = 8'h01;
        i_wakeup_pad_mask = 128'h3 << 16;
        i_no_standby_exit_mask = 128'h2 << 16;
        i_boot_func_mask = 128'h1 << 70;
        i_pad_in = ~128'h1;
        repeat (4) @(posedge i_sys_clk);
        chk("rst_drive", o_pad_medium_drive[7'h21], 8'h1);
        #1 i_arst_n = 1'b1;
        rd(PAD_TDO, 7'h16);
        rd(PAD_TDI, 7'h08);
        rd(7'h79, 7'h08);
        rd(PAD_TMS, 7'h08);
        rd(7'h00, 7'h00);
        chk("drive", o_pad_medium_drive[7'h21], 8'h1);
        chk("tdo_oe", o_pad_oe[7'h21], 8'h0);
        chk("in_off", o_periph_in[7'h10], 8'h0);
        chk("sel_in", o_selected_in[0], 8'h1);
        for (int k = 0; k < 4; k++) begin
            wr(7'h40 + 7'(k), 7'h04 | 7'(k));
        end
        wr(PAD_TDO, 7'h14);
        wr(7'h10, 7'h08);
        wr(7'h11, 7'h08);
        wr(7'h44, 7'h25);
        i_input_pad_select_field = 8'h00;
        settle(1);
        chk("out", o_pad_out[7'h43:7'h40], 8'hF);
        chk("oe", o_pad_oe[7'h43:7'h40], 8'hB);
        chk("gpio_oe", o_pad_oe[7'h21], 8'h1);
        chk("in", o_periph_in[7'h11:7'h10], 8'h3);
        chk("wake", o_wakeup_in[7'h11:7'h10], 8'h3);
        chk("irq", o_external_irq_line[7'h11:7'h10], 8'h3);
        chk("sel_in", o_selected_in[0], 8'h0);
        chk("nmi_oe", o_pad_oe[7'h44], 8'h0);
        chk("nmi", o_nmi_in[7'h44], 8'h1);
        i_standby = 1'b1;
        i_cfg_rd_pad = 7'h46;
        wr(7'h46, 7'h45);
        settle(1);
        chk("exit", o_standby_exit[7'h11:7'h10], 8'h1);
        rd(7'h46, 7'h05);
        chk("boot_oe", o_pad_oe[7'h46], 8'h0);
        i_booting = 1'b1;
        settle(1);
        chk("boot_oe", o_pad_oe[7'h46], 8'h1);
        conclude();
    end
endmodule
bind pad_function_multiplexer pad_mux_props chk (.*);
`default_nettype wire
